//--- src/ccsst_top.sv
// Common command handler with state store and self-test sequencer
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps

module ccsst_top
    import ccsst_pkg::*;
#(
    parameter int unsigned TEST_CYC = SELFTEST_CYC  // Self-test duration in cycles
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  cmd_code,        // Decoded command, ccsst_cmd_e
    input  wire logic        cmd_valid,       // Command strobe, held until taken
    input  wire logic        cmd_has_arg,     // Command carried an argument
    input  wire logic [7:0]  cmd_arg,         // Numeric argument
    input  wire logic        cmd_serial,      // Command arrived on the serial port
    output logic             cmd_ready,       // High while a new command is taken
    input  wire logic        powerup_recall_switch, // Power-up recall switch pin
    input  wire logic [2:0]  test_fail_code,  // Failing test number 1..6, 0 or 7 = pass
    output logic             reply_valid,     // One-cycle reply strobe
    output logic [15:0]      reply_data,      // Reply value
    output logic             reply_serial,    // Reply goes to the serial port
    output logic             disp_fail_msg,   // Display shows the failure message
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq
);

    // Location store, flip-flops indexed by location
    logic [STATE_W-1:0] store_reg [NUM_LOC];

    // All other state except the pin synchronisers in one struct
    typedef struct packed {
        ccsst_st_e           st;          // Sequencer state
        logic [31:0]         cnt;         // Self-test timer
        logic                boot;        // Power-up work still pending
        logic                tst_serial;  // Result goes to serial port
        logic                tst_cmd;     // Self-test was commanded
        logic [7:0]          esr;         // std_event_status_reg
        logic [STATE_W-1:0]  work;        // Working instrument state
        logic [7:0]          tst_res;     // Last self-test result
        logic [15:0]         err;         // Head of error queue
        logic                err_vld;     // Error queue holds an entry
        logic [IRQ_W-1:0]    istat;       // Sticky interrupt status
        logic [IRQ_W-1:0]    imask;       // Interrupt mask
        logic                disp;        // Failure message shown
        logic                rvld;        // Reply strobe
        logic [15:0]         rdat;        // Reply data
        logic                rser;        // Reply to serial
        logic [31:0]         rdata;       // Register read data
        logic                sav_en;      // Store write this cycle
        logic [3:0]          sav_loc;     // Store write location
    } ccsst_state_s;

    ccsst_state_s s_reg;
    ccsst_state_s s_next;

    // Two-flop synchronisers for the pins
    logic [3:0] sw_sync1_reg;
    logic [3:0] sw_sync2_reg;

    // Synchronise switch and failure code from outside the domain
    // No reset, so the pins are already through both flops when boot reads them
    always_ff @(posedge clk) begin
        sw_sync1_reg <= {powerup_recall_switch, test_fail_code};
        sw_sync2_reg <= sw_sync1_reg;
    end

    // Argument checks and location choice
    logic       loc_ok;
    logic [3:0] loc_sel;
    always_comb begin
        loc_ok  = !cmd_has_arg || (cmd_arg <= {4'h0, LOC_MAX});
        loc_sel = cmd_has_arg ? cmd_arg[3:0] : LOC_DEFAULT;
    end

    // Commands wait while the self-test runs, so replies follow order
    assign cmd_ready = (s_reg.st == CCSST_IDLE) && !s_reg.boot;

    // Next-state logic for the whole block
    always_comb begin
        logic [7:0]       res;
        logic             take;
        logic [IRQ_W-1:0] iev;
        logic [7:0]       eev;
        res    = 8'h00;
        take   = cmd_valid && cmd_ready;
        iev    = '0;
        eev    = '0;
        s_next = s_reg;
        s_next.rvld   = 1'b0;
        s_next.sav_en = 1'b0;
        s_next.rdata  = 32'h0;
        // Events gather on a clean slate and are merged before register writes
        s_next.istat  = '0;
        s_next.esr    = '0;

        // Sequencer
        unique case (s_reg.st)
            CCSST_IDLE: begin
                if (s_reg.boot) begin
                    // Power-up: optional recall, and the self-test starts in the same cycle
                    s_next.boot    = 1'b0;
                    s_next.st      = CCSST_TEST;
                    s_next.cnt     = 32'h0;
                    s_next.tst_cmd = 1'b0;
                    if (sw_sync2_reg[3]) begin
                        s_next.work = store_reg[LOC_POWERUP];
                    end
                end
            end
            CCSST_TEST: begin
                if (s_reg.cnt >= TEST_CYC - 1) begin
                    s_next.st = CCSST_DONE;
                end else begin
                    s_next.cnt = s_reg.cnt + 32'h1;
                end
            end
            CCSST_DONE: begin
                // Result is 0 or minus the failing test number
                res = (sw_sync2_reg[2:0] == 3'h0 || sw_sync2_reg[2:0] == 3'h7) ? TST_PASS
                    : 8'(-{5'h0, sw_sync2_reg[2:0]});
                s_next.tst_res = res;
                s_next.st      = CCSST_IDLE;
                s_next.istat[IRQ_TSTDONE] = 1'b1;
                if (res != TST_PASS) begin
                    s_next.err     = ERR_SELFTEST;
                    s_next.err_vld = 1'b1;
                    s_next.istat[IRQ_TSTFAIL] = 1'b1;
                    if (!s_reg.tst_cmd) begin
                        s_next.disp = 1'b1;
                    end
                end
                if (s_reg.tst_cmd) begin
                    // Commanded test answers with its result
                    s_next.rvld = 1'b1;
                    s_next.rdat = {{8{res[7]}}, res};
                    s_next.rser = s_reg.tst_serial;
                end
            end
        endcase

        // Command execution
        if (take) begin
            unique case (ccsst_cmd_e'(cmd_code))
                CCSST_CMD_OPC: begin
                    if (!cmd_has_arg) begin
                        s_next.esr[ESR_OPC_BIT] = 1'b1;
                        s_next.istat[IRQ_OPC]   = 1'b1;
                    end else begin
                        s_next.esr[ESR_EXE_BIT] = 1'b1;
                    end
                end
                CCSST_CMD_OPCQ: begin
                    s_next.rvld = 1'b1;
                    s_next.rdat = 16'h0001;
                    s_next.rser = cmd_serial;
                end
                CCSST_CMD_RCL: begin
                    if (loc_ok) begin
                        // Only the working state changes, never status
                        s_next.work = store_reg[loc_sel];
                    end else begin
                        s_next.err     = ERR_EXEC;
                        s_next.err_vld = 1'b1;
                        s_next.esr[ESR_EXE_BIT] = 1'b1;
                        s_next.istat[IRQ_EXEERR] = 1'b1;
                    end
                end
                CCSST_CMD_SAV: begin
                    if (loc_ok) begin
                        s_next.sav_en  = 1'b1;
                        s_next.sav_loc = loc_sel;
                    end else begin
                        s_next.err     = ERR_EXEC;
                        s_next.err_vld = 1'b1;
                        s_next.esr[ESR_EXE_BIT] = 1'b1;
                        s_next.istat[IRQ_EXEERR] = 1'b1;
                    end
                end
                CCSST_CMD_TRG, CCSST_CMD_WAI: begin
                    // Accepted, nothing changes
                    s_next.rvld = 1'b0;
                end
                CCSST_CMD_TST: begin
                    s_next.st         = CCSST_TEST;
                    s_next.cnt        = 32'h0;
                    s_next.tst_cmd    = 1'b1;
                    s_next.tst_serial = cmd_serial;
                end
                CCSST_CMD_DCLR: begin
                    s_next.disp = 1'b0;
                end
                CCSST_CMD_ERRQ: begin
                    // Reply carries the 16-bit error code, or zero when the queue is empty
                    s_next.rvld    = 1'b1;
                    s_next.rdat    = s_reg.err_vld ? s_reg.err : 16'h0000;
                    s_next.rser    = cmd_serial;
                    s_next.err_vld = 1'b0;
                end
                default: begin
                    s_next.rvld = 1'b0;
                end
            endcase
        end

        // Merge this cycle's events, so a same-cycle clear never loses a set
        iev          = s_next.istat;
        eev          = s_next.esr;
        s_next.istat = s_reg.istat | iev;
        s_next.esr   = s_reg.esr | eev;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_ESR: begin
                    s_next.esr = (s_reg.esr & ~reg_wdata[7:0]) | eev;
                end
                OFS_STATE_LO: begin
                    s_next.work[31:0] = reg_wdata;
                end
                OFS_STATE_HI: begin
                    s_next.work[63:32] = reg_wdata;
                end
                OFS_IRQ_STAT: begin
                    // Write one to clear, a same-cycle set wins
                    s_next.istat = (s_reg.istat & ~reg_wdata[IRQ_W-1:0]) | iev;
                end
                OFS_IRQ_MASK: begin
                    s_next.imask = reg_wdata[IRQ_W-1:0];
                end
                default: begin
                    s_next.rdata = 32'h0;
                end
            endcase
        end

        // Register reads, data one cycle later
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_ESR:      s_next.rdata = {24'h0, s_reg.esr};
                OFS_STATE_LO: s_next.rdata = s_reg.work[31:0];
                OFS_STATE_HI: s_next.rdata = s_reg.work[63:32];
                OFS_TST:      s_next.rdata = {{24{s_reg.tst_res[7]}}, s_reg.tst_res};
                OFS_ERR:      s_next.rdata = {15'h0, s_reg.err_vld, s_reg.err};
                OFS_IRQ_STAT: s_next.rdata = {28'h0, s_reg.istat};
                OFS_IRQ_MASK: s_next.rdata = {28'h0, s_reg.imask};
                OFS_DISP:     s_next.rdata = {31'h0, s_reg.disp};
                OFS_REPLY:    s_next.rdata = {14'h0, s_reg.rser, s_reg.rvld, s_reg.rdat};
                default:      s_next.rdata = 32'h0;
            endcase
        end
    end

    // Register the state struct
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg            <= '0;
            s_reg.st         <= CCSST_IDLE;
            s_reg.boot       <= 1'b1;
            s_reg.work       <= STATE_RST;
            s_reg.tst_res    <= TST_PASS;
        end else begin
            s_reg <= s_next;
        end
    end

    // Nonvolatile store, written one cycle after the save command
    // Not reset: saved states must survive a power cycle for the boot recall
    always_ff @(posedge clk) begin
        if (s_reg.sav_en) begin
            store_reg[s_reg.sav_loc] <= s_reg.work;
        end
    end

    // Outputs
    assign reply_valid   = s_reg.rvld;
    assign reply_data    = s_reg.rdat;
    assign reply_serial  = s_reg.rser;
    assign disp_fail_msg = s_reg.disp;
    assign reg_rdata     = s_reg.rdata;
    assign irq           = |(s_reg.istat & s_reg.imask);

endmodule

//--- shared/ccsst_pkg.sv
// Package for the common command, state store and self-test block
package ccsst_pkg;

    // Clock rate and timing
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned SELFTEST_MS   = 3000;
    localparam int unsigned SELFTEST_CYC  = (CLK_HZ / 1000) * SELFTEST_MS;

    // State store geometry
    localparam int unsigned NUM_LOC       = 10;
    localparam int unsigned STATE_W       = 64;
    localparam logic [3:0]  LOC_DEFAULT   = 4'h1;
    localparam logic [3:0]  LOC_POWERUP   = 4'h0;
    localparam logic [3:0]  LOC_MAX       = 4'h9;

    // Event status bit positions
    localparam int unsigned ESR_OPC_BIT   = 0;
    localparam int unsigned ESR_EXE_BIT   = 4;

    // Reset value of the working state
    localparam logic [STATE_W-1:0] STATE_RST = 64'h0;

    // Self-test result codes (two's complement, 8 bit)
    localparam logic [7:0]  TST_PASS      = 8'h00;

    // Error queue codes
    localparam logic [15:0] ERR_EXEC      = 16'hFF22;
    localparam logic [15:0] ERR_SELFTEST  = 16'hFEB6;

    // Interrupt status bit positions
    localparam int unsigned IRQ_W         = 4;
    localparam int unsigned IRQ_OPC       = 0;
    localparam int unsigned IRQ_TSTDONE   = 1;
    localparam int unsigned IRQ_TSTFAIL   = 2;
    localparam int unsigned IRQ_EXEERR    = 3;

    // Register offsets (byte addresses)
    localparam logic [7:0]  OFS_ESR       = 8'h00;
    localparam logic [7:0]  OFS_STATE_LO  = 8'h04;
    localparam logic [7:0]  OFS_STATE_HI  = 8'h08;
    localparam logic [7:0]  OFS_TST       = 8'h0C;
    localparam logic [7:0]  OFS_ERR       = 8'h10;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h18;
    localparam logic [7:0]  OFS_DISP      = 8'h1C;
    localparam logic [7:0]  OFS_REPLY     = 8'h20;

    // Command codes
    typedef enum logic [3:0] {
        CCSST_CMD_NONE,
        CCSST_CMD_OPC,
        CCSST_CMD_OPCQ,
        CCSST_CMD_RCL,
        CCSST_CMD_SAV,
        CCSST_CMD_TRG,
        CCSST_CMD_WAI,
        CCSST_CMD_TST,
        CCSST_CMD_DCLR,
        CCSST_CMD_ERRQ
    } ccsst_cmd_e;

    // Sequencer states
    typedef enum logic [1:0] {
        CCSST_IDLE,
        CCSST_TEST,
        CCSST_DONE
    } ccsst_st_e;

endpackage

//--- dv/ccsst_top_sva.sv
// Port checks for the common command block
`timescale 1ns/1ps
module ccsst_top_sva
    import ccsst_pkg::*;
#(
    parameter int unsigned TEST_CYC = SELFTEST_CYC // Self-test length
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  cmd_code,
    input wire logic        cmd_valid,
    input wire logic        cmd_has_arg,
    input wire logic [7:0]  cmd_arg,
    input wire logic        cmd_serial,
    input wire logic        cmd_ready,
    input wire logic        powerup_recall_switch,
    input wire logic [2:0]  test_fail_code,
    input wire logic        reply_valid,
    input wire logic [15:0] reply_data,
    input wire logic        reply_serial,
    input wire logic        disp_fail_msg,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq
);
    localparam int TST_LAT = TEST_CYC + 2; // Take to self-test reply
    logic take;                            // Command accepted this cycle
    assign take = cmd_valid && cmd_ready;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    opcq_reply_a: assert property (take && cmd_code == CCSST_CMD_OPCQ |=>
        reply_valid && reply_data == 16'h0001 && reply_serial == $past(cmd_serial))
        else $error("query reply missing or wrong");
    errq_reply_a: assert property (take && cmd_code == CCSST_CMD_ERRQ |=> reply_valid)
        else $error("error query not answered");
    tst_reply_a: assert property (take && cmd_code == CCSST_CMD_TST |-> ##TST_LAT
        reply_valid && reply_serial == $past(cmd_serial, TST_LAT))
        else $error("self-test reply late or on wrong port");
    tst_busy_a: assert property (take && cmd_code == CCSST_CMD_TST |=> !cmd_ready [*8])
        else $error("commands taken during self-test");
    boot_busy_a: assert property ($fell(rst) |-> !cmd_ready [*8])
        else $error("no boot self-test after reset");
    disp_clear_a: assert property ($fell(disp_fail_msg) |->
        $past(take && cmd_code == CCSST_CMD_DCLR))
        else $error("failure message dropped without clear");
    noop_cmd_a: assert property (take && (cmd_code == CCSST_CMD_TRG ||
        cmd_code == CCSST_CMD_WAI) |=> !reply_valid)
        else $error("trigger or wait produced a reply");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    irq_mask_a: assert property (reg_wr && reg_addr == OFS_IRQ_MASK &&
        reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("interrupt high with all masked");
    cover property (take && cmd_code == CCSST_CMD_TST);
    cover property ($fell(disp_fail_msg));
    cover property ($rose(irq));
endmodule

bind ccsst_top ccsst_top_sva #(.TEST_CYC(TEST_CYC)) ccsst_top_sva_inst (
    .clk(clk), .rst(rst), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
    .cmd_has_arg(cmd_has_arg), .cmd_arg(cmd_arg), .cmd_serial(cmd_serial),
    .cmd_ready(cmd_ready), .powerup_recall_switch(powerup_recall_switch),
    .test_fail_code(test_fail_code), .reply_valid(reply_valid), .reply_data(reply_data),
    .reply_serial(reply_serial), .disp_fail_msg(disp_fail_msg), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq));

//--- dv/ccsst_host.sv
// Host controller model that issues commands and holds each until taken
`timescale 1ns/1ps
module ccsst_host
    import ccsst_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  cmd_ready,
    output logic [3:0] cmd_code,
    output logic       cmd_valid,
    output logic       cmd_has_arg,
    output logic [7:0] cmd_arg,
    output logic       cmd_serial
);
    // Idle lines at time zero
    initial begin
        cmd_code = 4'h0;
        cmd_valid = 1'b0;
        cmd_has_arg = 1'b0;
        cmd_arg = 8'h00;
        cmd_serial = 1'b0;
    end
    // Hold until ready is seen; commands before boot ends are withheld
    task automatic send(input ccsst_cmd_e c, input logic h, input logic [7:0] a,
                        input logic s);
        @(posedge clk);
        cmd_code <= c;
        cmd_valid <= 1'b1;
        cmd_has_arg <= h;
        cmd_arg <= a;
        cmd_serial <= s;
        @(negedge clk);
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_has_arg <= 1'b0;
        cmd_arg <= ~a; // Released argument shows no stale value
    endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for the common command block
`timescale 1ns/1ps
module tb
    import ccsst_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, sw = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] fcode = 3'h3;         // Self-test failure source
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0] cmd_code;
    logic [7:0] cmd_arg;
    logic cmd_valid, cmd_has_arg, cmd_serial, cmd_ready, rep_v, rep_s, disp, irq;
    logic [15:0] rep_d, last_rep;
    logic last_ser;
    int fails = 0, check_count = 0, rep_cnt = 0;
    always #2.5 clk = ~clk;
    ccsst_host ccsst_host_inst (.clk(clk), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
        .cmd_valid(cmd_valid), .cmd_has_arg(cmd_has_arg), .cmd_arg(cmd_arg),
        .cmd_serial(cmd_serial));
    ccsst_top #(.TEST_CYC(20)) ccsst_top_inst (.clk(clk), .rst(rst), .cmd_code(cmd_code),
        .cmd_valid(cmd_valid), .cmd_has_arg(cmd_has_arg), .cmd_arg(cmd_arg),
        .cmd_serial(cmd_serial), .cmd_ready(cmd_ready), .powerup_recall_switch(sw),
        .test_fail_code(fcode), .reply_valid(rep_v), .reply_data(rep_d),
        .reply_serial(rep_s), .disp_fail_msg(disp), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq));
    // Capture each one-cycle reply
    always @(posedge clk) begin
        if (rep_v === 1'b1) begin
            last_rep <= rep_d;
            last_ser <= rep_s;
            rep_cnt <= rep_cnt + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic chkrd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wst(input logic [63:0] v);
        wr(OFS_STATE_LO, v[31:0]);
        wr(OFS_STATE_HI, v[63:32]);
    endtask
    task automatic chkst(input logic [63:0] v);
        chkrd(OFS_STATE_LO, v[31:0]);
        chkrd(OFS_STATE_HI, v[63:32]);
    endtask
    // Flags settle one cycle after the command is taken
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input ccsst_cmd_e c, input logic h, input logic [7:0] a);
        ccsst_host_inst.send(c, h, a, 1'b0);
    endtask
    // Command that answers; the reply port must match the request port
    task automatic q(input ccsst_cmd_e c, input logic s, input logic [15:0] exp);
        int n0;
        n0 = rep_cnt;
        ccsst_host_inst.send(c, 1'b0, 8'h00, s);
        for (int i = 0; i < 64 && rep_cnt == n0; i++) @(posedge clk);
        #1;
        chk(32'(rep_cnt - n0), 32'h1);
        chk({15'h0, last_ser, last_rep}, {15'h0, s, exp});
    endtask
    task automatic do_reset(input logic s);
        rst <= 1'b1;
        sw <= s;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(posedge clk);
        settle();
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict();
    end
    initial begin
        do_reset(1'b0);
        chk(disp, 1'b1);
        chkrd(OFS_DISP, 32'h1);
        q(CCSST_CMD_ERRQ, 1'b1, ERR_SELFTEST);
        chkrd(OFS_ERR, 32'h0000_FEB6);
        cmd(CCSST_CMD_TRG, 1'b0, 8'h00);
        cmd(CCSST_CMD_WAI, 1'b0, 8'h00);
        settle();
        chk(disp, 1'b1);
        chkrd(OFS_ESR, 32'h0);
        cmd(CCSST_CMD_DCLR, 1'b0, 8'h00);
        settle();
        chk(disp, 1'b0);
        fcode <= 3'h0;
        cmd(CCSST_CMD_OPC, 1'b0, 8'h00);
        chkrd(OFS_ESR, 32'h1);
        wr(OFS_ESR, 32'h1);
        cmd(CCSST_CMD_OPC, 1'b1, 8'h00);
        chkrd(OFS_ESR, 32'h10);
        q(CCSST_CMD_OPCQ, 1'b0, 16'h0001);
        wst(64'h0123_4567_89AB_CDEF);
        cmd(CCSST_CMD_SAV, 1'b1, 8'h09);
        wst(64'hFEDC_BA98_7654_3210);
        cmd(CCSST_CMD_SAV, 1'b0, 8'h00);
        wst(64'h5A5A_0000_A5A5_FFFF);
        cmd(CCSST_CMD_RCL, 1'b1, 8'h09);
        chkst(64'h0123_4567_89AB_CDEF);
        chkrd(OFS_ESR, 32'h10);
        cmd(CCSST_CMD_RCL, 1'b0, 8'h00);
        chkst(64'hFEDC_BA98_7654_3210);
        wr(OFS_ESR, 32'h10);
        wr(OFS_IRQ_MASK, 32'h8);
        cmd(CCSST_CMD_SAV, 1'b1, 8'h0A);
        settle();
        chk(irq, 1'b1);
        chkrd(OFS_ESR, 32'h10);
        q(CCSST_CMD_ERRQ, 1'b0, ERR_EXEC);
        cmd(CCSST_CMD_RCL, 1'b1, 8'h01);
        chkst(64'hFEDC_BA98_7654_3210);
        wr(OFS_IRQ_MASK, 32'h0);
        settle();
        chk(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h8);
        wr(OFS_IRQ_STAT, 32'h8);
        settle();
        chk(irq, 1'b0);
        chkrd(OFS_IRQ_STAT, 32'h7);
        chkrd(8'hFC, 32'h0);
        for (int c = 0; c < 7; c++) begin
            fcode <= 3'(c);
            repeat (4) @(posedge clk);
            q(CCSST_CMD_TST, 1'(c), 16'(-c));
            if (c != 0) q(CCSST_CMD_ERRQ, 1'b0, ERR_SELFTEST);
        end
        fcode <= 3'h0;
        chkrd(OFS_TST, 32'hFFFF_FFFA);
        wst(64'h1111_2222_3333_4444);
        cmd(CCSST_CMD_SAV, 1'b1, 8'h00);
        wst(64'h0);
        do_reset(1'b1);
        chkst(64'h1111_2222_3333_4444);
        chk(disp, 1'b0);
        give_verdict();
    end
endmodule
